/* File: bench/clock_buffer_smbus_powerup_ctrl_tb_top.sv */
module clock_buffer_smbus_powerup_ctrl_tb_top import clkbuf_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam logic [6:0] ta = 7'h55; // arbitrary value
  logic mclk = 1'b0, lclk = 1'b0, arst_n = 1'b0, sv = 1'b0, pg = 1'b0;
  logic ref_v = 1'b1, lock = 1'b1, fs = 1'b1;
  logic [1:0] bw = 2'h2;
  logic [5:0] oe_n = 6'h00;
  wire scl, sda;
  logic sda_out_q, sda_oe_q, fq, a;
  logic [1:0] pm;
  logic [5:0] run, drv;
  logic [7:0] r0;
  int failures = 0, checks = 0, cyc = 0, n;
  always #2.5 mclk = ~mclk;
  // odd offset keeps the link edges apart from mclk edges
  initial #1.3 forever #40 lclk = ~lclk;
  clock_buffer_smbus_powerup_ctrl #(.DELAY_CYC(POWERUP_DELAY_CYC), .TARGET_ADDR(ta)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .diff_comp_clk(lclk), .supply_valid(sv),
    .power_good_powerdown_n(pg), .ref_clk_valid(ref_v), .pll_locked(lock),
    .freq_select_pin(fs), .bandwidth_mode_pin(bw), .out_enable_pin_n(oe_n),
    .scl_in(scl), .sda_in(sda), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .pll_mode_q(pm), .freq_sel_q(fq), .diff_clock_run(run), .diff_clock_drive(drv));
  smbus_host host_u (.mclk(mclk), .dut_oe(sda_oe_q), .scl(scl), .sda(sda));
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task results;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // every byte the host writes must be acknowledged
  task send(input logic [7:0] b);
    host_u.xfer(b, 1'b1, r0, a);
    chk({7'h00, a}, 8'h00);
    chk({7'h00, sda_out_q}, 8'h00); // open drain only ever pulls low
  endtask
  task wr(input logic [7:0] n0, input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] x);
    host_u.start;
    send({ta, 1'b0});
    send(n0);
    send(x);
    send(d0);
    if (x > 8'h01) send(d1);
    host_u.stop;
  endtask
  task rd(input logic [7:0] n0, input logic [7:0] e0, input logic [7:0] e1);
    host_u.start;
    send({ta, 1'b0});
    send(n0);
    host_u.start;
    send({ta, 1'b1});
    host_u.xfer(8'hff, 1'b0, r0, a);
    chk(r0, BLOCK_READ_COUNT);
    host_u.xfer(8'hff, 1'b0, r0, a);
    chk(r0, e0);
    host_u.xfer(8'hff, 1'b1, r0, a);
    chk(r0, e1);
    chk({7'h00, a}, 8'h01); // target has let go by the host nack
    host_u.stop;
  endtask
  // hang guard sized well above the expected ~36000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      results;
    end
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    // reset spans two link falling edges: the initial low gives no edge event
    repeat (40) @(posedge mclk);
    #1;
    chk({5'h00, fq, pm}, 8'h00);
    chk({2'h0, drv}, 8'h00);
    arst_n = 1'b1;
    sv = 1'b1; // power-good still low while supply rises
    for (n = 0; n < POWERUP_TOTAL_MAX_CYC && run !== 6'h3f; n++) begin
      @(posedge mclk);
      #1;
      // early power-good leaves the delay alone to pace power-up
      if (n == 100) pg = 1'b1;
    end
    chk({7'h00, n > POWERUP_DELAY_CYC}, 8'h01);
    chk({7'h00, n < POWERUP_DELAY_MAX_CYC + 100}, 8'h01);
    chk({7'h00, n < POWERUP_TOTAL_MAX_CYC}, 8'h01);
    fs = 1'b0;
    bw = 2'h1;
    #800 chk({5'h00, fq, pm}, 8'h06); // straps moved after capture are ignored
    ref_v = 1'b0;
    #800 chk({2'h0, run}, 8'h00);
    ref_v = 1'b1;
    #800 chk({2'h0, run}, 8'h3f);
    lock = 1'b0;
    #800 chk({2'h0, run}, 8'h00);
    lock = 1'b1;
    #800 chk({2'h0, run}, 8'h3f);
    rd(8'h00, 8'h87, 8'hf7);
    // a foreign address is left unanswered
    host_u.start;
    host_u.xfer({7'h2a, 1'b0}, 1'b1, r0, a);
    host_u.stop;
    chk({7'h00, a}, 8'h01);
    wr(8'h00, 8'hff, 8'h00, 8'h02);
    #800 chk({pm, run}, 8'hc0);
    chk({2'h0, drv}, 8'h3f); // disabled outputs sit low/low, not floating
    rd(8'h00, 8'h8f, 8'h01);
    wr(8'h01, 8'h5a, 8'h00, 8'h01);
    oe_n = 6'h01;
    #800 chk({2'h0, run}, 8'h14);
    chk({2'h0, drv}, 8'h3e);
    rd(8'h01, 8'h53, 8'h00);
    wr(8'h00, 8'h00, 8'h00, 8'h01);
    chk({6'h00, pm}, 8'h02);
    pg = 1'b0;
    #800 chk({2'h0, drv}, 8'h00);
    // warm reset after the mode change; straps are then taken afresh
    arst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'b1;
    chk({5'h00, fq, pm}, 8'h00);
    chk({2'h0, drv}, 8'h00);
    pg = 1'b1;
    #800 chk({5'h00, fq, pm}, 8'h01); // new straps taken on this rise
    rd(8'h00, 8'h46, 8'hf7);
    results;
  end
endmodule

/* File: bench/smbus_host.sv */
// ----------------------------------------
// smbus host and wire model
// ----------------------------------------
module smbus_host (
  // clock used to pace the bit steps
  input wire logic mclk,
  // target pulls sda low while high
  input wire logic dut_oe,
  // open-drain lines with pull-ups
  output wire scl,
  output wire sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;
  // released lines float high through the pull-ups
  assign scl = ~scl_lo;
  assign sda = ~(sda_lo | dut_oe);
  // one quarter bit is 10 mclk, well above the 4 mclk sampling floor
  task q;
    repeat (10) @(posedge mclk);
    #1;
  endtask
  // start or repeated start: sda falls while scl is high
  task start;
    sda_lo = 1'b0; q; scl_lo = 1'b0; q; sda_lo = 1'b1; q; scl_lo = 1'b1; q;
  endtask
  // stop: sda rises while scl is high
  task stop;
    sda_lo = 1'b1; q; scl_lo = 1'b0; q; sda_lo = 1'b0; q;
  endtask
  // sda only changes while scl is low
  task bit_io(input logic b, output logic r);
    sda_lo = ~b; q; scl_lo = 1'b0; q; r = sda; q; scl_lo = 1'b1; q;
  endtask
  // msb first byte, then the ninth bit; ackb 1 releases sda
  task xfer(input logic [7:0] w, input logic ackb, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(ackb, a);
  endtask
endmodule

/* File: inc/clkbuf_pkg.sv */
package clkbuf_pkg;

  // ----------------------------------------------------------------------
  // clocking and power-up timing
  // ----------------------------------------------------------------------
  localparam real MCLK_PERIOD_NS = 5.0;
  localparam real POWERUP_DELAY_MIN_MS = 0.1;
  localparam real POWERUP_DELAY_MAX_MS = 0.3;
  localparam real POWERUP_TOTAL_MAX_MS = 1.8;
  localparam int POWERUP_DELAY_CYC =
    int'($ceil(POWERUP_DELAY_MIN_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int POWERUP_DELAY_MAX_CYC =
    int'($floor(POWERUP_DELAY_MAX_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int POWERUP_TOTAL_MAX_CYC =
    int'($floor(POWERUP_TOTAL_MAX_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int DELAY_CNT_W = 19;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_PLL_MODE_FREQ_CONFIG = 8'h00;
  localparam logic [7:0] REG_OUTPUT_ENABLE_CTRL_A = 8'h01;
  localparam logic [7:0] BLOCK_READ_COUNT = 8'h02;
  localparam int CFG_MODE_RB_LSB = 6;
  localparam int CFG_SOFT_OVERRIDE_BIT = 3;
  localparam int CFG_SOFT_MODE_LSB = 1;
  localparam int CFG_FREQ_BIT = 0;
  localparam logic CFG_SOFT_OVERRIDE_RST = 1'b0;
  localparam logic [1:0] CFG_SOFT_MODE_RST = 2'h3;
  localparam logic [5:0] OUT_ENABLE_RST = 6'h3f;
  localparam logic OUT_EN_RSVD3_VAL = 1'b0;
  localparam logic OUT_EN_RSVD0_VAL = 1'b1;
  localparam int NUM_OUTPUTS = 6;

  // ----------------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PWR_OFF    = 4'b0001,
    PWR_DELAY  = 4'b0010,
    PWR_WAIT   = 4'b0100,
    PWR_NORMAL = 4'b1000
  } pwr_state_t;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'b00001,
    BUS_RECV = 5'b00010,
    BUS_ACK  = 5'b00100,
    BUS_SEND = 5'b01000,
    BUS_SACK = 5'b10000
  } bus_state_t;

endpackage

/* File: logic/clock_buffer_smbus_powerup_ctrl.sv */
module clock_buffer_smbus_powerup_ctrl
  import clkbuf_pkg::*;
#(
  parameter int DELAY_CYC = POWERUP_DELAY_CYC,
  parameter logic [6:0] TARGET_ADDR = 7'h55 // arbitrary value
) (
  // clocks and reset
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic diff_comp_clk,
  // power and reference status
  input wire logic supply_valid,
  input wire logic power_good_powerdown_n,
  input wire logic ref_clk_valid,
  input wire logic pll_locked,
  // configuration straps
  input wire logic freq_select_pin,
  input wire logic [1:0] bandwidth_mode_pin,
  input wire logic [NUM_OUTPUTS-1:0] out_enable_pin_n,
  // smbus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_q,
  output logic sda_oe_q,
  // pll and output control
  output logic [1:0] pll_mode_q,
  output logic freq_sel_q,
  output logic [NUM_OUTPUTS-1:0] diff_clock_run,
  output logic [NUM_OUTPUTS-1:0] diff_clock_drive
);

  initial begin
    if (DELAY_CYC < POWERUP_DELAY_CYC || DELAY_CYC > POWERUP_DELAY_MAX_CYC
        || DELAY_CYC >= (1 << DELAY_CNT_W))
      $error("DELAY_CYC outside the power-up delay window");
  end

  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  logic [1:0] sup_sync_q, pg_sync_q, ref_sync_q, lock_sync_q, fs_sync_q;
  logic [1:0] bw0_sync_q, bw1_sync_q, scl_sync_q, sda_sync_q;
  logic sup_s, pg_s, ref_s, lock_s, scl_s, sda_s, scl_d1_q, sda_d1_q, pg_d1_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sup_sync_q <= 2'h0;
      pg_sync_q <= 2'h0;
      ref_sync_q <= 2'h0;
      lock_sync_q <= 2'h0;
      fs_sync_q <= 2'h0;
      bw0_sync_q <= 2'h0;
      bw1_sync_q <= 2'h0;
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      sup_sync_q <= {sup_sync_q[0], supply_valid};
      pg_sync_q <= {pg_sync_q[0], power_good_powerdown_n};
      ref_sync_q <= {ref_sync_q[0], ref_clk_valid};
      lock_sync_q <= {lock_sync_q[0], pll_locked};
      fs_sync_q <= {fs_sync_q[0], freq_select_pin};
      bw0_sync_q <= {bw0_sync_q[0], bandwidth_mode_pin[0]};
      bw1_sync_q <= {bw1_sync_q[0], bandwidth_mode_pin[1]};
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
    end
  end

  assign sup_s = sup_sync_q[1];
  assign pg_s = pg_sync_q[1];
  assign ref_s = ref_sync_q[1];
  assign lock_s = lock_sync_q[1];
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];

  // delayed copies for edge detection, taken from the second stage only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      pg_d1_q <= 1'b0;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
      pg_d1_q <= pg_s;
    end
  end

  // -----------------------------------------------------------------------
  // power-up state machine
  // -----------------------------------------------------------------------
  pwr_state_t pwr_q, pwr_d;
  logic [DELAY_CNT_W-1:0] delay_cnt_q;
  logic run_q;

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_OFF: if (sup_s) pwr_d = PWR_DELAY;
      PWR_DELAY: if (delay_cnt_q == DELAY_CNT_W'(DELAY_CYC - 1)) pwr_d = PWR_WAIT;
      PWR_WAIT: if (ref_s && pg_s && lock_s) pwr_d = PWR_NORMAL;
      PWR_NORMAL: if (!ref_s || !pg_s || !lock_s) pwr_d = PWR_WAIT;
      default: pwr_d = PWR_OFF;
    endcase
    if (!sup_s) pwr_d = PWR_OFF;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pwr_q <= PWR_OFF;
    else pwr_q <= pwr_d;
  end

  // the wait runs at its shortest legal length to leave margin for lock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) delay_cnt_q <= '0;
    else if (pwr_q != PWR_DELAY) delay_cnt_q <= '0;
    else delay_cnt_q <= delay_cnt_q + 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) run_q <= 1'b0;
    else run_q <= (pwr_d == PWR_NORMAL);
  end

  // -----------------------------------------------------------------------
  // strap capture on first power-good rise
  // -----------------------------------------------------------------------
  logic straps_taken_q;
  logic [1:0] mode_latched_q;
  logic freq_latched_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      straps_taken_q <= 1'b0;
      mode_latched_q <= 2'h0;
      freq_latched_q <= 1'b0;
    end else if (!sup_s) begin
      straps_taken_q <= 1'b0;
    end else if (pg_s && !pg_d1_q && !straps_taken_q) begin
      straps_taken_q <= 1'b1; // later rises are powerdown exits only
      mode_latched_q <= {bw1_sync_q[1], bw0_sync_q[1]};
      freq_latched_q <= fs_sync_q[1];
    end
  end

  // -----------------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------------
  logic soft_override_q;
  logic [1:0] soft_mode_q;
  logic [NUM_OUTPUTS-1:0] out_en_q;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic [7:0] index_q;
  logic [7:0] rd_data;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      soft_override_q <= CFG_SOFT_OVERRIDE_RST;
      soft_mode_q <= CFG_SOFT_MODE_RST;
      out_en_q <= OUT_ENABLE_RST;
    end else if (wr_pulse) begin
      // only writable fields are taken, the rest of the byte is dropped
      if (index_q == REG_PLL_MODE_FREQ_CONFIG) begin
        soft_override_q <= wr_data[CFG_SOFT_OVERRIDE_BIT];
        soft_mode_q <= wr_data[CFG_SOFT_MODE_LSB +: 2];
      end else if (index_q == REG_OUTPUT_ENABLE_CTRL_A) begin
        out_en_q <= {wr_data[7:4], wr_data[2:1]};
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (index_q == REG_PLL_MODE_FREQ_CONFIG) begin
      rd_data[CFG_MODE_RB_LSB +: 2] = mode_latched_q;
      rd_data[CFG_SOFT_OVERRIDE_BIT] = soft_override_q;
      rd_data[CFG_SOFT_MODE_LSB +: 2] = soft_mode_q;
      rd_data[CFG_FREQ_BIT] = freq_latched_q;
    end else if (index_q == REG_OUTPUT_ENABLE_CTRL_A) begin
      rd_data = {out_en_q[5:2], OUT_EN_RSVD3_VAL, out_en_q[1:0], OUT_EN_RSVD0_VAL};
    end
  end

  // the new mode is presented at once; the system owns the warm reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pll_mode_q <= 2'h0;
      freq_sel_q <= 1'b0;
    end else begin
      pll_mode_q <= soft_override_q ? soft_mode_q : mode_latched_q;
      freq_sel_q <= freq_latched_q;
    end
  end

  // -----------------------------------------------------------------------
  // smbus target
  // -----------------------------------------------------------------------
  bus_state_t bus_q;
  logic [7:0] shreg_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_no_q;
  logic read_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise = scl_s & ~scl_d1_q;
  assign scl_fall = ~scl_s & scl_d1_q;
  assign bus_start = scl_s & scl_d1_q & ~sda_s & sda_d1_q;
  assign bus_stop = scl_s & scl_d1_q & sda_s & ~sda_d1_q;
  assign wr_pulse = (bus_q == BUS_RECV) && scl_fall && bit_cnt_q == 4'h8
                    && byte_no_q == 2'h3;
  assign wr_data = shreg_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= BUS_IDLE;
      shreg_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      byte_no_q <= 2'h0;
      read_q <= 1'b0;
      index_q <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      // start or repeated start: the index survives for the read phase
      bus_q <= BUS_RECV;
      bit_cnt_q <= 4'h0;
      byte_no_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      bus_q <= BUS_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (bus_q)
        BUS_IDLE: sda_oe_q <= 1'b0;
        BUS_RECV: begin
          if (scl_rise && bit_cnt_q != 4'h8) begin
            shreg_q <= {shreg_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bus_q <= BUS_ACK;
            sda_oe_q <= 1'b1;
            unique case (byte_no_q)
              2'h0: begin
                if (shreg_q[7:1] != TARGET_ADDR) begin
                  bus_q <= BUS_IDLE; // not ours, stay off the bus
                  sda_oe_q <= 1'b0;
                end
                read_q <= shreg_q[0];
              end
              2'h1: index_q <= shreg_q;
              2'h2: ; // count is acknowledged, stop ends the write
              2'h3: index_q <= index_q + 8'h01;
            endcase
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (read_q && byte_no_q == 2'h0) begin
              bus_q <= BUS_SEND;
              shreg_q <= BLOCK_READ_COUNT;
              sda_oe_q <= ~BLOCK_READ_COUNT[7];
            end else begin
              bus_q <= BUS_RECV;
              sda_oe_q <= 1'b0;
              if (byte_no_q != 2'h3) byte_no_q <= byte_no_q + 2'h1;
            end
          end
        end
        BUS_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              bus_q <= BUS_SACK;
              sda_oe_q <= 1'b0;
            end else begin
              shreg_q <= {shreg_q[6:0], 1'b0};
              sda_oe_q <= ~shreg_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        BUS_SACK: begin
          if (scl_rise && sda_s) begin
            bus_q <= BUS_IDLE; // host nack ends the read
          end else if (scl_fall) begin
            bus_q <= BUS_SEND;
            bit_cnt_q <= 4'h0;
            shreg_q <= rd_data;
            sda_oe_q <= ~rd_data[7];
            index_q <= index_q + 8'h01;
          end
        end
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  // open drain: the data line is only ever pulled low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) sda_out_q <= 1'b0;
    else sda_out_q <= 1'b0;
  end

  // -----------------------------------------------------------------------
  // link domain: powerdown and output gates
  // -----------------------------------------------------------------------
  logic [1:0] pd_sync_q;
  logic [1:0] pd_low_cnt_q;
  logic tri_all_q;

  always_ff @(posedge diff_comp_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_sync_q <= 2'h0;
      pd_low_cnt_q <= 2'h0;
    end else begin
      pd_sync_q <= {pd_sync_q[0], power_good_powerdown_n};
      if (pd_sync_q[1]) pd_low_cnt_q <= 2'h0;
      else if (pd_low_cnt_q != 2'h2) pd_low_cnt_q <= pd_low_cnt_q + 2'h1;
    end
  end

  // a stopped link clock holds the gates in their last state; only reset forces them off
  always_ff @(negedge diff_comp_clk or negedge arst_n) begin
    if (!arst_n) tri_all_q <= 1'b1;
    else tri_all_q <= (pd_low_cnt_q == 2'h2);
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : gen_out
      out_gate u_gate (
        .diff_comp_clk(diff_comp_clk),
        .arst_n(arst_n),
        .run_req(run_q),
        .enable_bit(out_en_q[g]),
        .oe_pin_n(out_enable_pin_n[g]),
        .tri_all(tri_all_q),
        .out_run_q(diff_clock_run[g]),
        .out_drive_q(diff_clock_drive[g])
      );
    end
  endgenerate

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  property p_delay_min;
    @(posedge mclk) disable iff (!arst_n)
      (pwr_q == PWR_DELAY && delay_cnt_q != DELAY_CNT_W'(DELAY_CYC - 1) && sup_s)
      |=> pwr_q == PWR_DELAY;
  endproperty
  a_delay_min: assert property (p_delay_min) else $error("delay left early");

  property p_wait_hold;
    @(posedge mclk) disable iff (!arst_n)
      (pwr_q == PWR_WAIT && !(pg_s && ref_s)) |=> pwr_q != PWR_NORMAL;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait without inputs");

  property p_lock_first;
    @(posedge mclk) disable iff (!arst_n)
      $rose(run_q) |-> $past(lock_s) && pwr_q == PWR_NORMAL;
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("outputs on without lock");

  property p_no_ref;
    @(posedge mclk) disable iff (!arst_n) !ref_s |=> !run_q;
  endproperty
  a_no_ref: assert property (p_no_ref) else $error("run without reference");

  property p_mode_ro;
    @(posedge mclk) disable iff (!arst_n)
      (wr_pulse && !(pg_s && !pg_d1_q)) |=> $stable(mode_latched_q) && $stable(freq_latched_q);
  endproperty
  a_mode_ro: assert property (p_mode_ro) else $error("latched bits changed by write");

  property p_override;
    @(posedge mclk) disable iff (!arst_n)
      soft_override_q |=> pll_mode_q == $past(soft_mode_q);
  endproperty
  a_override: assert property (p_override) else $error("override mode not applied");

  property p_addr_ack;
    @(posedge mclk) disable iff (!arst_n)
      (bus_q == BUS_RECV && scl_fall && bit_cnt_q == 4'h8 && byte_no_q == 2'h0
       && shreg_q[7:1] == TARGET_ADDR && !bus_start && !bus_stop) |=> sda_oe_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_index_step;
    @(posedge mclk) disable iff (!arst_n)
      (wr_pulse && !bus_start && !bus_stop) |=> index_q == $past(index_q) + 8'h01;
  endproperty
  a_index_step: assert property (p_index_step) else $error("index did not advance");

  property p_count_first;
    @(posedge mclk) disable iff (!arst_n)
      (bus_q == BUS_ACK && scl_fall && read_q && byte_no_q == 2'h0 && !bus_start && !bus_stop)
      |=> bus_q == BUS_SEND && shreg_q == BLOCK_READ_COUNT;
  endproperty
  a_count_first: assert property (p_count_first) else $error("count not sent first");

  property p_reserved_rd;
    @(posedge mclk) disable iff (!arst_n)
      index_q == REG_PLL_MODE_FREQ_CONFIG |-> rd_data[5:4] == 2'h0;
  endproperty
  a_reserved_rd: assert property (p_reserved_rd) else $error("reserved bits nonzero");

  c_normal: cover property (@(posedge mclk) disable iff (!arst_n) $rose(run_q));
  c_write: cover property (@(posedge mclk) disable iff (!arst_n) wr_pulse);
  c_read: cover property (@(posedge mclk) disable iff (!arst_n) bus_q == BUS_SACK);
  c_pwrdn: cover property (@(posedge mclk) disable iff (!arst_n) $fell(pg_s) && run_q);

endmodule

/* File: logic/out_gate.sv */
module out_gate
  import clkbuf_pkg::*;
(
  // link clock and reset
  input wire logic diff_comp_clk,
  input wire logic arst_n,
  // controls from other domains and pins
  input wire logic run_req,
  input wire logic enable_bit,
  input wire logic oe_pin_n,
  input wire logic tri_all,
  // driver controls
  output logic out_run_q,
  output logic out_drive_q
);

  logic [1:0] run_sync_q;
  logic [1:0] en_sync_q;
  logic [1:0] oe_sync_q;

  // -----------------------------------------------------------------------
  // synchronisers, each first stage read only by its second
  // -----------------------------------------------------------------------
  always_ff @(negedge diff_comp_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_sync_q <= 2'h0;
      en_sync_q <= 2'h0;
      oe_sync_q <= 2'h3;
    end else begin
      run_sync_q <= {run_sync_q[0], run_req};
      en_sync_q <= {en_sync_q[0], enable_bit};
      oe_sync_q <= {oe_sync_q[0], oe_pin_n};
    end
  end

  // -----------------------------------------------------------------------
  // gating
  // -----------------------------------------------------------------------
  // updated while the comp leg is low so a pulse is never cut short
  always_ff @(negedge diff_comp_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_run_q <= 1'b0;
      out_drive_q <= 1'b0;
    end else begin
      out_run_q <= run_sync_q[1] & en_sync_q[1] & ~oe_sync_q[1] & ~tri_all;
      // bit clear drives low/low; pin high with bit set floats
      out_drive_q <= ~tri_all & ~(en_sync_q[1] & oe_sync_q[1]);
    end
  end

  property p_gate_off;
    @(negedge diff_comp_clk) disable iff (!arst_n)
      (!en_sync_q[1] || oe_sync_q[1] || tri_all) |=> !out_run_q;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("output ran while gated off");

  property p_bit_low_low;
    @(negedge diff_comp_clk) disable iff (!arst_n)
      (!en_sync_q[1] && !tri_all) |=> (out_drive_q && !out_run_q);
  endproperty
  a_bit_low_low: assert property (p_bit_low_low) else $error("disabled output not low/low");

endmodule
